/* shared/pdm_consts.vh */
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH

// register offsets on the plain register port
`define PDM_ADDR_A_LATCH 4'h0
`define PDM_ADDR_A_DIR 4'h1
`define PDM_ADDR_A_PIN 4'h2
`define PDM_ADDR_B_LATCH 4'h3
`define PDM_ADDR_B_DIR 4'h4
`define PDM_ADDR_B_PIN 4'h5
`define PDM_ADDR_C_LATCH 4'h6
`define PDM_ADDR_D_LATCH 4'h7
`define PDM_ADDR_D_DIR 4'h8
`define PDM_ADDR_D_PIN 4'h9
`define PDM_ADDR_E_LATCH 4'ha
`define PDM_ADDR_E_DIR 4'hb
`define PDM_ADDR_E_PIN 4'hc
`define PDM_ADDR_CTRL 4'hd

// control register fields
`define PDM_CTRL_XMEM 0
`define PDM_CTRL_PUD 1

// reset values
`define PDM_RST_LATCH 8'h00
`define PDM_RST_DIR 8'h00
`define PDM_RST_CTRL 2'h0

// pin numbers inside the flat pin vector {E[2:0], D, B, A}
`define PDM_PIN_COUNT 27
`define PDM_D_BASE 16
`define PDM_E_BASE 24

`endif

/* logic/pdm_pin_cell.v */
`timescale 1ns/1ns
`include "pdm_consts.vh"

module pdm_pin_cell (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register settings
    input wire latchBit,
    input wire dirBit,
    input wire pullupDisable,
    input wire inputEnable,
    // override controls
    input wire pullupOverrideEnable,
    input wire pullupOverrideValue,
    input wire directionOverrideEnable,
    input wire directionOverrideValue,
    input wire valueOverrideEnable,
    input wire valueOverrideValue,
    input wire inputEnableOverrideEnable,
    input wire inputEnableOverrideValue,
    // pad side
    input wire padIn,
    output reg padOut_q,
    output reg padOeN_q,
    output reg padPullup_q,
    // sampled level
    output reg pinSample_q
);

    reg sync1_q;
    reg sync2_q;
    wire dirEff;
    wire dieEff;

    // each override enable replaces the register setting
    assign dirEff = directionOverrideEnable ? directionOverrideValue : dirBit;
    assign dieEff = inputEnableOverrideEnable ? inputEnableOverrideValue : inputEnable;

    // pad drive, registered so the pad never sees a glitching mux
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            padOut_q <= 1'b0;
            padOeN_q <= 1'b1;
            padPullup_q <= 1'b0;
        end else begin
            padOut_q <= valueOverrideEnable ? valueOverrideValue : latchBit;
            padOeN_q <= ~dirEff;
            padPullup_q <= pullupOverrideEnable ? pullupOverrideValue
                : (latchBit & ~dirBit & ~pullupDisable);
        end
    end

    // two-flop synchroniser, then input gate
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            pinSample_q <= 1'b0;
        end else begin
            sync1_q <= padIn;
            sync2_q <= sync1_q;
            pinSample_q <= dieEff & sync2_q;
        end
    end

endmodule

/* logic/pdm_port_mux.v */
`timescale 1ns/1ns
`include "pdm_consts.vh"

// How it works
// - memory enable: PD7 drives read strobe
// - memory enable: PD6 drives store strobe
// - PD5 carries compare A when enabled
// - PD4 direction picks serial clock role
// - serial clock only in synchronous mode
// - PD3 interrupt forces input enable on
// - PD2 interrupt forces input enable on
// - PD2 direction picks second clock role
// - transmitter forces PD1 output, no pull-up
// - receiver forces PD0 input, feeds receiver
// - PD0 pull-up follows latch and disable
// - PE2 carries compare B when enabled
// - memory enable: PE1 drives latch enable
// - PE0 sample feeds capture trigger
// - PE0 interrupt forces input enable on
// - direction registers reset to inputs
// - output latches reset to zero
// - pin registers return sampled levels
module pdm_port_mux (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register port
    input wire [3:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdata_q,
    // peripheral controls
    input wire sleepInputGate,
    input wire extMemReadStrobe,
    input wire extMemStoreStrobe,
    input wire extMemAddrLatchEnable,
    input wire timer1CompareAEnable,
    input wire timer1CompareAOut,
    input wire timer1CompareBEnable,
    input wire timer1CompareBOut,
    input wire serialSyncMode,
    input wire serialClockOut,
    input wire transmitterEnable,
    input wire transmitData,
    input wire receiverEnable,
    input wire extIrqZeroEnable,
    input wire extIrqOneEnable,
    input wire extIrqTwoEnable,
    // values to peripherals
    output reg receiveData_q,
    output reg serialClockIn_q,
    output reg secondClockIn_q,
    output reg extIrqZeroInput_q,
    output reg extIrqOneInput_q,
    output reg extIrqTwoInput_q,
    output reg captureTriggerInput_q,
    output reg [7:0] portCLatch_q,
    // pads {E[2:0], D, B, A}
    input wire [26:0] padIn,
    output wire [26:0] padOut,
    output wire [26:0] padOeN,
    output wire [26:0] padPullup
);

    // software-visible register state
    reg [7:0] aLatch_q;
    reg [7:0] aDir_q;
    reg [7:0] bLatch_q;
    reg [7:0] bDir_q;
    reg [7:0] dLatch_q;
    reg [7:0] dDir_q;
    reg [2:0] eLatch_q;
    reg [2:0] eDir_q;
    reg [1:0] ctrl_q;
    reg [7:0] rdData_d;

    // decoded control bits and flat per-pin vectors
    wire extMemEnable;
    wire pullupDisable;
    wire serialClockOutEnable;
    wire [26:0] latchAll;
    wire [26:0] dirAll;
    wire [26:0] pinSample;
    // override vectors, one bit per pin, built by the table below
    reg [26:0] pullup_override_enable;
    reg [26:0] pullup_override_value;
    reg [26:0] direction_override_enable;
    reg [26:0] direction_override_value;
    reg [26:0] value_override_enable;
    reg [26:0] value_override_value;
    reg [26:0] input_enable_override_enable;
    reg [26:0] input_enable_override_value;

    // control register fields and flattened register views
    assign extMemEnable = ctrl_q[`PDM_CTRL_XMEM];
    assign pullupDisable = ctrl_q[`PDM_CTRL_PUD];
    assign latchAll = {eLatch_q, dLatch_q, bLatch_q, aLatch_q};
    assign dirAll = {eDir_q, dDir_q, bDir_q, aDir_q};

    // serial clock drives out only in synchronous mode with direction set
    assign serialClockOutEnable = serialSyncMode & dDir_q[4];

    // register writes; the pin registers have no write path at all
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aLatch_q <= `PDM_RST_LATCH;
            bLatch_q <= `PDM_RST_LATCH;
            portCLatch_q <= `PDM_RST_LATCH;
            dLatch_q <= `PDM_RST_LATCH;
            eLatch_q <= 3'h0;
            aDir_q <= `PDM_RST_DIR;
            bDir_q <= `PDM_RST_DIR;
            dDir_q <= `PDM_RST_DIR;
            eDir_q <= 3'h0;
            ctrl_q <= `PDM_RST_CTRL;
        end else if (regWr) begin
            // one register per offset; port e and ctrl keep low bits only
            case (regAddr)
                `PDM_ADDR_A_LATCH: aLatch_q <= regWdata;
                `PDM_ADDR_A_DIR: aDir_q <= regWdata;
                `PDM_ADDR_B_LATCH: bLatch_q <= regWdata;
                `PDM_ADDR_B_DIR: bDir_q <= regWdata;
                `PDM_ADDR_C_LATCH: portCLatch_q <= regWdata;
                `PDM_ADDR_D_LATCH: dLatch_q <= regWdata;
                `PDM_ADDR_D_DIR: dDir_q <= regWdata;
                `PDM_ADDR_E_LATCH: eLatch_q <= regWdata[2:0];
                `PDM_ADDR_E_DIR: eDir_q <= regWdata[2:0];
                `PDM_ADDR_CTRL: ctrl_q <= regWdata[1:0];
                default: ; // pin registers and holes ignore writes
            endcase
        end
    end

    // read mux; unmapped offsets and unused port E bits read zero
    always @* begin
        rdData_d = 8'h00;
        case (regAddr)
            `PDM_ADDR_A_LATCH: rdData_d = aLatch_q;
            `PDM_ADDR_A_DIR: rdData_d = aDir_q;
            `PDM_ADDR_A_PIN: rdData_d = pinSample[7:0];
            `PDM_ADDR_B_LATCH: rdData_d = bLatch_q;
            `PDM_ADDR_B_DIR: rdData_d = bDir_q;
            `PDM_ADDR_B_PIN: rdData_d = pinSample[15:8];
            `PDM_ADDR_C_LATCH: rdData_d = portCLatch_q;
            `PDM_ADDR_D_LATCH: rdData_d = dLatch_q;
            `PDM_ADDR_D_DIR: rdData_d = dDir_q;
            `PDM_ADDR_D_PIN: rdData_d = pinSample[23:16];
            `PDM_ADDR_E_LATCH: rdData_d = {5'h00, eLatch_q};
            `PDM_ADDR_E_DIR: rdData_d = {5'h00, eDir_q};
            `PDM_ADDR_E_PIN: rdData_d = {5'h00, pinSample[26:24]};
            `PDM_ADDR_CTRL: rdData_d = {6'h00, ctrl_q};
            default: rdData_d = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdata_q <= 8'h00;
        end else if (regRd) begin
            regRdata_q <= rdData_d;
        end else begin
            regRdata_q <= 8'h00;
        end
    end

    // override table; ports a and b carry no overrides in this block.
    // every port d and e pin lists all eight controls, so a role that
    // leaves a control alone shows as an explicit zero, not a default
    always @* begin
        pullup_override_enable = 27'h0;
        pullup_override_value = 27'h0;
        direction_override_enable = 27'h0;
        direction_override_value = 27'h0;
        value_override_enable = 27'h0;
        value_override_value = 27'h0;
        input_enable_override_enable = 27'h0;
        input_enable_override_value = 27'h0;
        // pd7 read strobe
        pullup_override_enable[`PDM_D_BASE + 7] = extMemEnable;
        pullup_override_value[`PDM_D_BASE + 7] = 1'b0;
        direction_override_enable[`PDM_D_BASE + 7] = extMemEnable;
        direction_override_value[`PDM_D_BASE + 7] = 1'b1;
        value_override_enable[`PDM_D_BASE + 7] = extMemEnable;
        value_override_value[`PDM_D_BASE + 7] = extMemReadStrobe;
        input_enable_override_enable[`PDM_D_BASE + 7] = 1'b0;
        input_enable_override_value[`PDM_D_BASE + 7] = 1'b0;
        // pd6 store strobe
        pullup_override_enable[`PDM_D_BASE + 6] = extMemEnable;
        pullup_override_value[`PDM_D_BASE + 6] = 1'b0;
        direction_override_enable[`PDM_D_BASE + 6] = extMemEnable;
        direction_override_value[`PDM_D_BASE + 6] = 1'b1;
        value_override_enable[`PDM_D_BASE + 6] = extMemEnable;
        value_override_value[`PDM_D_BASE + 6] = extMemStoreStrobe;
        input_enable_override_enable[`PDM_D_BASE + 6] = 1'b0;
        input_enable_override_value[`PDM_D_BASE + 6] = 1'b0;
        // pd5 compare a; direction stays with the register
        pullup_override_enable[`PDM_D_BASE + 5] = 1'b0;
        pullup_override_value[`PDM_D_BASE + 5] = 1'b0;
        direction_override_enable[`PDM_D_BASE + 5] = 1'b0;
        direction_override_value[`PDM_D_BASE + 5] = 1'b0;
        value_override_enable[`PDM_D_BASE + 5] = timer1CompareAEnable;
        value_override_value[`PDM_D_BASE + 5] = timer1CompareAOut;
        input_enable_override_enable[`PDM_D_BASE + 5] = 1'b0;
        input_enable_override_value[`PDM_D_BASE + 5] = 1'b0;
        // pd4 serial clock out; direction stays with the register
        pullup_override_enable[`PDM_D_BASE + 4] = 1'b0;
        pullup_override_value[`PDM_D_BASE + 4] = 1'b0;
        direction_override_enable[`PDM_D_BASE + 4] = 1'b0;
        direction_override_value[`PDM_D_BASE + 4] = 1'b0;
        value_override_enable[`PDM_D_BASE + 4] = serialClockOutEnable;
        value_override_value[`PDM_D_BASE + 4] = serialClockOut;
        input_enable_override_enable[`PDM_D_BASE + 4] = 1'b0;
        input_enable_override_value[`PDM_D_BASE + 4] = 1'b0;
        // pd3 interrupt one keeps the input alive in sleep
        pullup_override_enable[`PDM_D_BASE + 3] = 1'b0;
        pullup_override_value[`PDM_D_BASE + 3] = 1'b0;
        direction_override_enable[`PDM_D_BASE + 3] = 1'b0;
        direction_override_value[`PDM_D_BASE + 3] = 1'b0;
        value_override_enable[`PDM_D_BASE + 3] = 1'b0;
        value_override_value[`PDM_D_BASE + 3] = 1'b0;
        input_enable_override_enable[`PDM_D_BASE + 3] = extIrqOneEnable;
        input_enable_override_value[`PDM_D_BASE + 3] = 1'b1;
        // pd2 interrupt zero, also the second clock pin
        pullup_override_enable[`PDM_D_BASE + 2] = 1'b0;
        pullup_override_value[`PDM_D_BASE + 2] = 1'b0;
        direction_override_enable[`PDM_D_BASE + 2] = 1'b0;
        direction_override_value[`PDM_D_BASE + 2] = 1'b0;
        value_override_enable[`PDM_D_BASE + 2] = 1'b0;
        value_override_value[`PDM_D_BASE + 2] = 1'b0;
        input_enable_override_enable[`PDM_D_BASE + 2] = extIrqZeroEnable;
        input_enable_override_value[`PDM_D_BASE + 2] = 1'b1;
        // pd1 transmit data
        pullup_override_enable[`PDM_D_BASE + 1] = transmitterEnable;
        pullup_override_value[`PDM_D_BASE + 1] = 1'b0;
        direction_override_enable[`PDM_D_BASE + 1] = transmitterEnable;
        direction_override_value[`PDM_D_BASE + 1] = 1'b1;
        value_override_enable[`PDM_D_BASE + 1] = transmitterEnable;
        value_override_value[`PDM_D_BASE + 1] = transmitData;
        input_enable_override_enable[`PDM_D_BASE + 1] = 1'b0;
        input_enable_override_value[`PDM_D_BASE + 1] = 1'b0;
        // pd0 receive data, pull-up still software controlled
        pullup_override_enable[`PDM_D_BASE] = receiverEnable;
        pullup_override_value[`PDM_D_BASE] = dLatch_q[0] & ~pullupDisable;
        direction_override_enable[`PDM_D_BASE] = receiverEnable;
        direction_override_value[`PDM_D_BASE] = 1'b0;
        value_override_enable[`PDM_D_BASE] = 1'b0;
        value_override_value[`PDM_D_BASE] = 1'b0;
        input_enable_override_enable[`PDM_D_BASE] = 1'b0;
        input_enable_override_value[`PDM_D_BASE] = 1'b0;
        // pe2 compare b; direction stays with the register
        pullup_override_enable[`PDM_E_BASE + 2] = 1'b0;
        pullup_override_value[`PDM_E_BASE + 2] = 1'b0;
        direction_override_enable[`PDM_E_BASE + 2] = 1'b0;
        direction_override_value[`PDM_E_BASE + 2] = 1'b0;
        value_override_enable[`PDM_E_BASE + 2] = timer1CompareBEnable;
        value_override_value[`PDM_E_BASE + 2] = timer1CompareBOut;
        input_enable_override_enable[`PDM_E_BASE + 2] = 1'b0;
        input_enable_override_value[`PDM_E_BASE + 2] = 1'b0;
        // pe1 address latch enable
        pullup_override_enable[`PDM_E_BASE + 1] = extMemEnable;
        pullup_override_value[`PDM_E_BASE + 1] = 1'b0;
        direction_override_enable[`PDM_E_BASE + 1] = extMemEnable;
        direction_override_value[`PDM_E_BASE + 1] = 1'b1;
        value_override_enable[`PDM_E_BASE + 1] = extMemEnable;
        value_override_value[`PDM_E_BASE + 1] = extMemAddrLatchEnable;
        input_enable_override_enable[`PDM_E_BASE + 1] = 1'b0;
        input_enable_override_value[`PDM_E_BASE + 1] = 1'b0;
        // pe0 interrupt two and capture trigger
        pullup_override_enable[`PDM_E_BASE] = 1'b0;
        pullup_override_value[`PDM_E_BASE] = 1'b0;
        direction_override_enable[`PDM_E_BASE] = 1'b0;
        direction_override_value[`PDM_E_BASE] = 1'b0;
        value_override_enable[`PDM_E_BASE] = 1'b0;
        value_override_value[`PDM_E_BASE] = 1'b0;
        input_enable_override_enable[`PDM_E_BASE] = extIrqTwoEnable;
        input_enable_override_value[`PDM_E_BASE] = 1'b1;
    end

    // one cell per pin; the cells hold the pad flops, so every pad
    // output is registered and no override mux glitch reaches a pin
    genvar gi;
    generate
        for (gi = 0; gi < `PDM_PIN_COUNT; gi = gi + 1) begin : gPin
            pdm_pin_cell uCell (
                // clock and reset
                .sys_clk(sys_clk),
                .rst(rst),
                // register settings
                .latchBit(latchAll[gi]),
                .dirBit(dirAll[gi]),
                .pullupDisable(pullupDisable),
                .inputEnable(~sleepInputGate),
                // override controls
                .pullupOverrideEnable(pullup_override_enable[gi]),
                .pullupOverrideValue(pullup_override_value[gi]),
                .directionOverrideEnable(direction_override_enable[gi]),
                .directionOverrideValue(direction_override_value[gi]),
                .valueOverrideEnable(value_override_enable[gi]),
                .valueOverrideValue(value_override_value[gi]),
                .inputEnableOverrideEnable(input_enable_override_enable[gi]),
                .inputEnableOverrideValue(input_enable_override_value[gi]),
                // pad side
                .padIn(padIn[gi]),
                .padOut_q(padOut[gi]),
                .padOeN_q(padOeN[gi]),
                .padPullup_q(padPullup[gi]),
                // sampled level
                .pinSample_q(pinSample[gi])
            );
        end
    endgenerate

    // sampled levels handed to the peripherals; one extra stage so each
    // output is a flop even where a role gate sits in front of it
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            receiveData_q <= 1'b0;
            serialClockIn_q <= 1'b0;
            secondClockIn_q <= 1'b0;
            extIrqZeroInput_q <= 1'b0;
            extIrqOneInput_q <= 1'b0;
            extIrqTwoInput_q <= 1'b0;
            captureTriggerInput_q <= 1'b0;
        end else begin
            // role gates, so an idle peripheral sees a quiet zero
            receiveData_q <= receiverEnable & pinSample[`PDM_D_BASE];
            serialClockIn_q <= serialSyncMode & ~dDir_q[4]
                & pinSample[`PDM_D_BASE + 4];
            secondClockIn_q <= ~dDir_q[2] & pinSample[`PDM_D_BASE + 2];
            // interrupts see the pin even when it is an output
            extIrqZeroInput_q <= pinSample[`PDM_D_BASE + 2];
            extIrqOneInput_q <= pinSample[`PDM_D_BASE + 3];
            extIrqTwoInput_q <= pinSample[`PDM_E_BASE];
            captureTriggerInput_q <= pinSample[`PDM_E_BASE];
        end
    end

endmodule

/* verification/pdm_pad_world.sv */
`timescale 1ns/1ns

module pdm_pad_world (
    // clock
    input wire sys_clk,
    // pad side of the mux
    input wire [26:0] padOut,
    input wire [26:0] padOeN,
    input wire [26:0] padPullup,
    // outside drivers
    input wire [26:0] extEn,
    input wire [26:0] extVal,
    // resolved pad levels
    output wire [26:0] padIn
);
    reg toggle_q = 1'b0;

    // floating pads wander, so a stale level never passes for a driven one
    always @(posedge sys_clk) begin
        toggle_q <= ~toggle_q;
    end

    // chip drive wins, then outside drive, then pull-up
    assign padIn = (~padOeN & padOut) | (padOeN & extEn & extVal)
        | (padOeN & ~extEn & (padPullup | {27{toggle_q}}));
endmodule

/* verification/pdm_mux_sva.sv */
`timescale 1ns/1ns
`include "pdm_consts.vh"

module pdm_mux_sva (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register port
    input wire [3:0] regAddr,
    input wire [7:0] regWdata,
    input wire regWr,
    // peripheral controls
    input wire sleepInputGate,
    input wire extMemReadStrobe,
    input wire extMemStoreStrobe,
    input wire extMemAddrLatchEnable,
    input wire timer1CompareAEnable,
    input wire timer1CompareAOut,
    input wire serialSyncMode,
    input wire serialClockOut,
    input wire transmitterEnable,
    input wire transmitData,
    input wire receiverEnable,
    input wire extIrqTwoEnable,
    input wire captureTriggerInput_q,
    // pads
    input wire [26:0] padIn,
    input wire [26:0] padOut,
    input wire [26:0] padOeN,
    input wire [26:0] padPullup
);
    reg [1:0] ctrlCopy_q;
    reg dLat0Copy_q;
    reg [7:0] dDirCopy_q;

    // shadow copies of the registers the overrides depend on
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrlCopy_q <= 2'h0;
            dLat0Copy_q <= 1'b0;
            dDirCopy_q <= 8'h00;
        end else if (regWr) begin
            if (regAddr == `PDM_ADDR_CTRL) ctrlCopy_q <= regWdata[1:0];
            if (regAddr == `PDM_ADDR_D_LATCH) dLat0Copy_q <= regWdata[0];
            if (regAddr == `PDM_ADDR_D_DIR) dDirCopy_q <= regWdata;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_read_strobe_pin: assert property (ctrlCopy_q[0] |=>
        !padOeN[23] && !padPullup[23] && padOut[23] == $past(extMemReadStrobe)) else $error("read strobe pin");
    a_store_strobe_pin: assert property (ctrlCopy_q[0] |=>
        !padOeN[22] && !padPullup[22] && padOut[22] == $past(extMemStoreStrobe)) else $error("store strobe pin");
    a_latch_enable_pin: assert property (ctrlCopy_q[0] |=>
        !padOeN[25] && !padPullup[25] && padOut[25] == $past(extMemAddrLatchEnable)) else $error("latch enable pin");
    a_tx_forced_out: assert property (transmitterEnable |=>
        !padOeN[17] && !padPullup[17] && padOut[17] == $past(transmitData)) else $error("tx pin");
    a_rx_forced_in: assert property (receiverEnable |=>
        padOeN[16] && padPullup[16] == ($past(dLat0Copy_q) && !$past(ctrlCopy_q[1]))) else $error("rx pin");
    a_compare_a_pin: assert property (timer1CompareAEnable && dDirCopy_q[5] |=>
        !padOeN[21] && padOut[21] == $past(timer1CompareAOut)) else $error("compare a pin");
    a_sync_clock_out: assert property (serialSyncMode && dDirCopy_q[4] |=>
        !padOeN[20] && padOut[20] == $past(serialClockOut)) else $error("sync clock pin");
    a_capture_path: assert property (extIrqTwoEnable [*5] |->
        captureTriggerInput_q == $past(padIn[24], 4)) else $error("capture input path");
    a_reset_inputs: assert property ($fell(rst) |->
        &padOeN && padOut == 27'h0) else $error("pads after reset");

    c_ext_memory: cover property (ctrlCopy_q[0] && extMemReadStrobe);
    c_rx_no_pullup: cover property (receiverEnable && ctrlCopy_q[1]);
    c_irq_in_sleep: cover property (extIrqTwoEnable && sleepInputGate);
endmodule

bind pdm_port_mux pdm_mux_sva u_sva (.*);

/* verification/tb.sv */
`timescale 1ns/1ns
`include "pdm_consts.vh"

module tb;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg [3:0] regAddr = 4'h0;
    reg [7:0] regWdata = 8'h00;
    reg regWr = 1'b0;
    reg regRd = 1'b0;
    reg [15:0] ctl = 16'h0000;
    reg [26:0] extEn = 27'h0;
    reg [26:0] extVal = 27'h0;
    wire [7:0] regRdata_q;
    wire [7:0] portCLatch_q;
    wire [6:0] per;
    wire [26:0] padIn;
    wire [26:0] padOut;
    wire [26:0] padOeN;
    wire [26:0] padPullup;
    integer n_fail = 0;
    integer tests_run = 0;
    integer cyc = 0;
    integer i;

    always #5 sys_clk = ~sys_clk;

    pdm_port_mux u_dut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q), .sleepInputGate(ctl[0]),
        .extMemReadStrobe(ctl[1]), .extMemStoreStrobe(ctl[2]), .extMemAddrLatchEnable(ctl[3]),
        .timer1CompareAEnable(ctl[4]), .timer1CompareAOut(ctl[5]), .timer1CompareBEnable(ctl[6]),
        .timer1CompareBOut(ctl[7]), .serialSyncMode(ctl[8]), .serialClockOut(ctl[9]),
        .transmitterEnable(ctl[10]), .transmitData(ctl[11]), .receiverEnable(ctl[12]),
        .extIrqZeroEnable(ctl[13]), .extIrqOneEnable(ctl[14]), .extIrqTwoEnable(ctl[15]),
        .receiveData_q(per[0]), .serialClockIn_q(per[1]), .secondClockIn_q(per[2]),
        .extIrqZeroInput_q(per[3]), .extIrqOneInput_q(per[4]), .extIrqTwoInput_q(per[5]),
        .captureTriggerInput_q(per[6]), .portCLatch_q(portCLatch_q), .padIn(padIn),
        .padOut(padOut), .padOeN(padOeN), .padPullup(padPullup));

    pdm_pad_world u_world (.sys_clk(sys_clk), .padOut(padOut), .padOeN(padOeN),
        .padPullup(padPullup), .extEn(extEn), .extVal(extVal), .padIn(padIn));

    task final_report;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // one-cycle write strobe
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge sys_clk);
            regWr <= 1'b1;
            regAddr <= a;
            regWdata <= d;
            @(posedge sys_clk);
            regWr <= 1'b0;
        end
    endtask

    // read data stands only in the cycle after the strobe
    task rd(input [3:0] a, input [7:0] e);
        begin
            @(posedge sys_clk);
            regRd <= 1'b1;
            regAddr <= a;
            @(posedge sys_clk);
            regRd <= 1'b0;
            #1 chk(regRdata_q, e);
        end
    endtask

    // set controls and outside drive, then let the 4-flop input path settle
    task sc(input [15:0] c, input [26:0] en, input [26:0] v);
        begin
            @(posedge sys_clk);
            ctl <= c;
            extEn <= en;
            extVal <= v;
            repeat (6) @(posedge sys_clk);
            #1;
        end
    endtask

    // hang guard, well above the few hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        #1 chk(padOeN, 27'h7ffffff);
        chk(portCLatch_q, 8'h00);
        for (i = 0; i < 14; i = i + 1)
            if (i != 2 && i != 5 && i != 9 && i != 12) rd(i[3:0], 8'h00);
        // distinct pattern per register, port E keeps three bits
        for (i = 0; i < 12; i = i + 1)
            if (i != 2 && i != 5 && i != 9) begin
                wr(i[3:0], 8'h5a ^ i[7:0]);
                rd(i[3:0], (i > 9) ? ((8'h5a ^ i[7:0]) & 8'h07) : (8'h5a ^ i[7:0]));
            end
        rd(4'he, 8'h00);
        sc(16'h0000, 27'h0, 27'h0);
        chk(portCLatch_q, 8'h5c);
        chk(padOeN[7:0], 8'ha4);
        // pin register reads pads; writing it changes nothing
        wr(4'h0, 8'h00);
        wr(4'h1, 8'h00);
        sc(16'h0000, 27'hff, 27'h3c);
        rd(4'h2, 8'h3c);
        wr(4'h2, 8'hff);
        rd(4'h0, 8'h00);
        rd(4'h1, 8'h00);
        chk(padOeN[7:0], 8'hff);
        // memory interface takes PD7, PD6, PE1 over pull-ups
        wr(4'h7, 8'hff);
        wr(4'h8, 8'h00);
        wr(4'ha, 8'h07);
        wr(4'hb, 8'h00);
        wr(4'hd, 8'h01);
        sc(16'h000a, 27'h0, 27'h0);
        chk({padOeN[25], padOeN[23:22]}, 3'b000);
        chk({padOut[25], padOut[23:22]}, 3'b110);
        chk({padPullup[25], padPullup[23:21]}, 4'b0001);
        wr(4'hd, 8'h00);
        sc(16'h0000, 27'h0, 27'h0);
        chk({padOeN[23], padPullup[23]}, 2'b11);
        // serial transmit and receive pins
        sc(16'h0c00, 27'h0, 27'h0);
        chk({padOeN[17], padOut[17], padPullup[17]}, 3'b010);
        wr(4'h8, 8'h01);
        sc(16'h1000, 27'h10000, 27'h10000);
        chk({padOeN[16], padPullup[16], per[0]}, 3'b111);
        wr(4'hd, 8'h02);
        sc(16'h1000, 27'h10000, 27'h10000);
        chk(padPullup[16], 1'b0);
        wr(4'hd, 8'h00);
        // compare outputs need the direction bit
        wr(4'h8, 8'h20);
        wr(4'hb, 8'h04);
        sc(16'h0050, 27'h0, 27'h0);
        chk({padOeN[26], padOeN[21], padOut[26], padOut[21]}, 4'b0000);
        wr(4'h8, 8'h00);
        wr(4'hb, 8'h00);
        sc(16'h0050, 27'h0, 27'h0);
        chk({padOeN[26], padOeN[21]}, 2'b11);
        // serial clock pin only in synchronous mode
        wr(4'h8, 8'h10);
        sc(16'h0100, 27'h0, 27'h0);
        chk({padOeN[20], padOut[20]}, 2'b00);
        sc(16'h0000, 27'h0, 27'h0);
        chk(padOut[20], 1'b1);
        wr(4'h8, 8'h00);
        sc(16'h0100, 27'h100000, 27'h100000);
        chk(per[1], 1'b1);
        // interrupt enables keep pins sampled while asleep
        sc(16'he001, 27'h10c0000, 27'h10c0000);
        chk(per[6:2], 5'h1f);
        sc(16'h0001, 27'h10c0000, 27'h10c0000);
        rd(4'h9, 8'h00);
        chk(per[6:2], 5'h00);
        final_report;
    end
endmodule
